// ==== logic/pixel_link_pkg.sv ====
/*
   Package for the graphics-side pixel transfer block of the feature connector.
   Holds timing constants, limits and the packed carriers shared by the design.
   Assumes a 125 MHz system clock that samples every connector pin.
*/
package pixel_link_pkg;

   // System clock period in picoseconds (8 ns)
   localparam int unsigned CLOCK_PERIOD_PS   = 8000;
   // Fastest allowed connector clock, 37.5 MHz, as a least period in ps
   localparam int unsigned LINK_MIN_PERIOD_PS = 26667;
   // Least system cycles per connector clock period, rounded up
   localparam int unsigned LINK_MIN_CYCLES   =
      (LINK_MIN_PERIOD_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

   // Reset values
   localparam logic [31:0] PIXEL_RESET       = 32'h0000_0000;
   localparam logic [7:0]  DIVIDE_RESET      = 8'h04;
   localparam logic [7:0]  GENLOCK_DIV_RESET = 8'h04;
   localparam logic [7:0]  GENLOCK_DLY_RESET = 8'h02;

   // Transfer direction of the pixel bus
   typedef enum logic [1:0] {
      MODE_IDLE   = 2'b00,   // Nothing moves
      MODE_OUTPUT = 2'b01,   // Graphics drives pixels out
      MODE_INPUT  = 2'b10    // Video board pushes pixels in
   } link_mode_t;

   // A pixel word with its qualifier
   typedef struct packed {
      logic        valid;    // Word is a real pixel
      logic [31:0] data;     // Pixel value
   } pixel_word_t;

   // Line timing from the display pipeline
   typedef struct packed {
      logic hsync;           // Line sync, high during sync
      logic vsync;           // Frame sync
      logic visible;         // Inside visible display area
   } line_timing_t;

endpackage

// ==== logic/pixel_link.sv ====
/*
   Graphics-side pixel transfer logic for the feature connector: output mode
   (display clock, blanking, pixel words out), input mode (ready handshake,
   pixels in on the video clock) and a genlock clock aligned to line sync.
   Assumes connector inputs are asynchronous to clock and that the display
   pipeline supplies line timing and pixels on clock.
*/
// Overview of operation
// - Sample both readies on video clock rise
// - Output mode: graphics alone sources pixels
// - Display clock divided from internal clock
// - Blanking low outside visible pixels ignored
// - Output mode ignores both ready signals
// - Fixed sync-to-genlock delay every line
// - Genlock clock programmable, at most 37.5MHz
// - Display and video clocks limited 37.5 MHz
// - Burst of N: ready for N-1; the code needs ready for N
// - Bus direction follows video direction control
// - Full-width input modes use video ready
`timescale 1ns/1ns
module pixel_link
   import pixel_link_pkg::*;
#(
   parameter int unsigned DIV_WIDTH = 8    // Width of divider settings
) (
   input  wire logic                 clock,             // System clock, 125 MHz
   input  wire logic                 reset_n,           // Synchronous reset, active low
   input  wire link_mode_t           mode,              // Requested transfer mode
   input  wire logic [DIV_WIDTH-1:0] display_divide,    // Display clock half period in cycles
   input  wire logic [DIV_WIDTH-1:0] genlock_divide,    // Genlock half period in cycles
   input  wire logic [DIV_WIDTH-1:0] genlock_delay,     // Cycles from sync end to genlock rise
   input  wire logic                 genlock_enable,    // Run genlock clock
   input  wire line_timing_t         timing,            // Line timing from display pipeline
   input  wire logic [31:0]          out_pixel,         // Pixel to send in output mode
   output logic                      out_pixel_taken,   // Pulse: out_pixel latched for the bus
   input  wire logic                 in_accept,         // Graphics can take another input pixel
   output pixel_word_t               in_word,           // Received input pixel, one-cycle valid
   input  wire logic [31:0]          pixel_in,          // Pixel bus, input side
   output logic [31:0]               pixel_out,         // Pixel bus, output side
   output logic                      pixel_oe,          // Pixel bus drive enable, high drives
   input  wire logic                 video_clock,       // Video clock from the video board
   input  wire logic                 video_ready,       // Video ready from the video board
   output logic                      graphics_ready,    // Graphics ready to the video board
   output logic                      video_direction_n, // Low: video drives the pixel bus
   output logic                      display_clock,     // Display clock to the connector
   output logic                      blank_n,           // Blanking, low outside visible area
   output logic                      hsync_out,         // Line sync to the connector
   output logic                      vsync_out,         // Frame sync to the connector
   output logic                      genlock_clock      // Genlock clock to the connector
);

   // Dividers below LINK_MIN_CYCLES/2 would overrun the connector clock limit
   initial begin
      if (DIV_WIDTH < 2 || DIV_WIDTH > 16) begin
         $error("pixel_link: DIV_WIDTH out of range");
      end
   end

   // Half period floor so that a full period never beats 37.5 MHz
   localparam logic [DIV_WIDTH-1:0] MIN_HALF = DIV_WIDTH'((LINK_MIN_CYCLES + 1) / 2);

   logic [DIV_WIDTH-1:0] display_half;       // Clamped display half period
   logic [DIV_WIDTH-1:0] genlock_half;       // Clamped genlock half period
   logic [DIV_WIDTH-1:0] display_count;      // Display divider count
   logic [DIV_WIDTH-1:0] genlock_count;      // Genlock divider count
   logic [DIV_WIDTH-1:0] delay_count;        // Sync-to-genlock delay count
   logic                 delay_run;          // Delay in progress
   logic                 hsync_prev;         // Line sync one cycle ago
   logic                 sync_trailing;      // Line sync just ended
   logic                 display_rise;       // Display clock about to rise
   logic [2:0]           video_clock_sync;          // Video clock synchroniser and history
   logic [1:0]           video_ready_sync;          // Video ready synchroniser
   logic [31:0]          pixel_s1;           // Pixel bus first stage
   logic [31:0]          pixel_s2;           // Pixel bus second stage
   logic                 video_clock_rise;          // Rising video clock seen
   logic                 output_mode;        // Output mode active
   logic                 input_mode;         // Input mode active

   // Clamp both programmed clocks to the connector limit
   assign display_half = (display_divide < MIN_HALF) ? MIN_HALF : display_divide;
   assign genlock_half = (genlock_divide < MIN_HALF) ? MIN_HALF : genlock_divide;
   assign output_mode  = (mode == MODE_OUTPUT);
   assign input_mode   = (mode == MODE_INPUT);
   assign sync_trailing = hsync_prev && !timing.hsync;
   assign display_rise  = !display_clock && (display_count >= display_half - 1'b1);
   // Second and third stages only: the first stage feeds nothing else
   assign video_clock_rise     = video_clock_sync[1] && !video_clock_sync[2];

   // Display clock: integer division of the system clock, runs in output mode
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         display_count <= '0;
         display_clock <= 1'b0;
      end else if (!output_mode) begin
         display_count <= '0;
         display_clock <= 1'b0;
      end else if (display_count >= display_half - 1'b1) begin
         display_count <= '0;
         display_clock <= !display_clock;
      end else begin
         display_count <= display_count + 1'b1;
      end
   end

   // Output pixels, blanking and syncs change with the display clock rise
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pixel_out       <= PIXEL_RESET;
         blank_n         <= 1'b0;
         hsync_out       <= 1'b0;
         vsync_out       <= 1'b0;
         out_pixel_taken <= 1'b0;
      end else begin
         out_pixel_taken <= 1'b0;
         if (output_mode && display_rise) begin
            blank_n   <= timing.visible;
            hsync_out <= timing.hsync;
            vsync_out <= timing.vsync;
            // Ready signals play no part here
            if (timing.visible) begin
               pixel_out       <= out_pixel;
               out_pixel_taken <= 1'b1;
            end
         end else if (!output_mode) begin
            blank_n <= 1'b0;
         end
      end
   end

   // Bus direction: graphics drives only in output mode
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pixel_oe          <= 1'b0;
         video_direction_n <= 1'b1;
      end else begin
         pixel_oe          <= output_mode;
         video_direction_n <= !input_mode;
      end
   end

   // Synchronisers for the video clock, video ready and pixel bus
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         video_clock_sync <= 3'b000;
         video_ready_sync <= 2'b00;
         pixel_s1  <= PIXEL_RESET;
         pixel_s2  <= PIXEL_RESET;
      end else begin
         video_clock_sync <= {video_clock_sync[1:0], video_clock};
         video_ready_sync <= {video_ready_sync[0], video_ready};
         pixel_s1  <= pixel_in;
         pixel_s2  <= pixel_s1;
      end
   end

   // Input handshake on each video clock rise; ready is only offered for the
   // next word, so a burst of N needs ready high for N edges
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         graphics_ready <= 1'b0;
         in_word        <= '{valid: 1'b0, data: PIXEL_RESET};
      end else begin
         in_word.valid <= 1'b0;
         if (!input_mode) begin
            graphics_ready <= 1'b0;
         end else if (video_clock_rise) begin
            // Full-width input needs video ready as well
            if (graphics_ready && video_ready_sync[1]) begin
               in_word <= '{valid: 1'b1, data: pixel_s2};
            end
            // Otherwise the video board holds its word
            graphics_ready <= in_accept && timing.visible;
         end
      end
   end

   // Genlock clock: fixed delay from line sync end, then free division
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         hsync_prev    <= 1'b0;
         delay_run     <= 1'b0;
         delay_count   <= '0;
         genlock_count <= '0;
         genlock_clock <= 1'b0;
      end else begin
         hsync_prev <= timing.hsync;
         if (!genlock_enable) begin
            delay_run     <= 1'b0;
            genlock_clock <= 1'b0;
         end else if (sync_trailing) begin
            // Restart each line so the phase never drifts
            delay_run     <= 1'b1;
            delay_count   <= '0;
            genlock_clock <= 1'b0;
         end else if (delay_run) begin
            if (delay_count >= genlock_delay) begin
               delay_run     <= 1'b0;
               genlock_count <= '0;
               genlock_clock <= 1'b1;
            end else begin
               delay_count <= delay_count + 1'b1;
            end
         end else if (genlock_count >= genlock_half - 1'b1) begin
            genlock_count <= '0;
            genlock_clock <= !genlock_clock;
         end else begin
            genlock_count <= genlock_count + 1'b1;
         end
      end
   end

endmodule // pixel_link

// ==== test/pixel_link_props.sv ====
/* Checker for the pixel link: port-level relations of output mode, input mode and genlock.
   Assumes it is bound to every pixel_link instance and sees only its ports. */
`timescale 1ns/1ns
module pixel_link_props
   import pixel_link_pkg::*;
#(
   parameter int unsigned DIV_WIDTH = 8    // Width of divider settings
) (
   input wire logic                 clock, reset_n, genlock_enable, in_accept, out_pixel_taken, // Controls
   input wire link_mode_t           mode,          // Requested mode
   input wire logic [DIV_WIDTH-1:0] genlock_delay, // Sync-to-genlock delay
   input wire line_timing_t         timing,        // Line timing
   input wire pixel_word_t          in_word,       // Received word
   input wire logic                 pixel_oe, graphics_ready, video_direction_n, // Bus side
   input wire logic                 display_clock, blank_n, genlock_clock         // Connector clocks
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Driving the bus while the video side owns it would fight its drivers
   dir_oe_a: assert property (pixel_oe |-> video_direction_n) else $error("bus driven in input direction");
   display_clock_oe_a: assert property (display_clock |-> pixel_oe) else $error("display clock without bus drive");
   display_clock_mode_a: assert property ($rose(display_clock) |-> $past(mode) == MODE_OUTPUT)
      else $error("display clock outside output mode");
   // Half period of at least two cycles keeps the link at or under its top rate
   display_clock_high_a: assert property ($rose(display_clock) && mode == MODE_OUTPUT |=> display_clock)
      else $error("display clock high too short");
   display_clock_low_a: assert property ($fell(display_clock) && mode == MODE_OUTPUT |=> !display_clock)
      else $error("display clock low too short");
   taken_edge_a: assert property (out_pixel_taken |-> $rose(display_clock) && blank_n)
      else $error("pixel taken off a visible display edge");
   ready_idle_a: assert property (mode != MODE_INPUT [*2] |-> !graphics_ready) else $error("ready outside input");
   ready_cause_a: assert property ($rose(graphics_ready) |-> $past(in_accept && timing.visible))
      else $error("ready raised without room");
   word_once_a: assert property (in_word.valid |-> !video_direction_n && !$past(in_word.valid))
      else $error("input word outside a single edge");
   genlock_gap_a: assert property ($fell(timing.hsync) && genlock_enable && genlock_delay >= 3
      |-> ##2 !genlock_clock [*2]) else $error("genlock not restarted at line sync");
   cover property (out_pixel_taken);
   cover property (in_word.valid);
   cover property ($rose(genlock_clock));
endmodule // pixel_link_props
bind pixel_link pixel_link_props #(.DIV_WIDTH(DIV_WIDTH)) u_props (.clock(clock), .reset_n(reset_n),
   .genlock_enable(genlock_enable), .in_accept(in_accept), .out_pixel_taken(out_pixel_taken), .mode(mode),
   .genlock_delay(genlock_delay), .timing(timing), .in_word(in_word), .pixel_oe(pixel_oe),
   .graphics_ready(graphics_ready), .video_direction_n(video_direction_n), .display_clock(display_clock),
   .blank_n(blank_n), .genlock_clock(genlock_clock));

// ==== test/video_board_model.sv ====
/* Behavioural video board: makes a 125 ns video clock and pushes counting pixel words.
   Assumes graphics_ready comes from the graphics side; clock stands still while disabled. */
`timescale 1ns/1ns
module video_board_model (
   input  wire logic  enable,         // Run the link and push words
   input  wire logic  graphics_ready, // Ready from the graphics side
   output logic       video_clock,    // Video clock to the graphics side
   output logic       video_ready,    // Video side ready
   output logic [31:0] pixel_in       // Pixel word on the bus
);
   logic [31:0] word  = 32'h0000_0001; // Next word to deliver
   int          edges = 0;              // Own clock edges seen
   logic        both;                   // Handshake sampled at the edge
   initial begin
      video_clock = 1'b0;
      video_ready = 1'b1;
      pixel_in    = ~word;
      forever begin
         #62;
         if (enable) begin
            video_clock = 1'b1;
            both = graphics_ready & video_ready;
            #40;
            // Word only advances when both sides were ready, otherwise it is held
            if (both) word = word + 32'h0000_0001;
            edges++;
            video_ready = (edges % 5) != 0; // Stall every fifth edge
            pixel_in = word;
            #23 video_clock = 1'b0;
         end else begin
            pixel_in = ~pixel_in; // Released bus alternates between the held word and its complement
            #63;
         end
      end
   end
endmodule // video_board_model

// ==== test/feature_connector_pixel_transfer_bench.sv ====
/* Self-checking bench for the pixel link: output rows, blanking, genlock lines, input stream, resets.
   Assumes the checker is bound and the video board model sits on the far side. */
`timescale 1ns/1ns
module feature_connector_pixel_transfer_bench;
   import pixel_link_pkg::*;
   typedef struct {logic [7:0] div; int half;} row_t;
   logic clock = 1'b0, reset_n = 1'b0, genlock_enable = 1'b0, in_accept = 1'b0, vid_en = 1'b0; // Drives
   link_mode_t   mode = MODE_IDLE;                                                       // Mode request
   logic [7:0]   display_divide = 8'h04, genlock_divide = 8'h03, genlock_delay = 8'h03;  // Settings
   line_timing_t timing = '0;                                                            // Line timing
   logic [31:0]  out_pixel = 32'h0000_0000, pixel_in, pixel_out, expect_word = 32'h0000_0001;
   pixel_word_t  in_word;                                                                // Received word
   logic out_pixel_taken, pixel_oe, video_clock, video_ready, graphics_ready, video_direction_n;
   logic display_clock, blank_n, hsync_out, vsync_out, genlock_clock;                    // Connector
   int   error_cnt = 0, samples_checked = 0, cycles = 0, n, meas [3];
   row_t rows [3] = '{'{8'h01, 2}, '{8'h02, 2}, '{8'h05, 5}}; // Divider below two is clamped
   pixel_link DUT (.*);
   video_board_model vid (.enable(vid_en), .graphics_ready, .video_clock, .video_ready, .pixel_in);
   initial forever #4 clock = ~clock;
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tick(); @(posedge clock); #1; endtask
   task automatic wait_display_clock(logic lvl);
      for (int i = 0; i < 300 && display_clock !== lvl; i++) tick();
   endtask
   // Cuts a hang short; the whole run needs well under this
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin error_cnt++; wrap_up(); end
   end
   initial begin
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      tick();
      check("reset outputs", {pixel_oe, graphics_ready, display_clock, genlock_clock, video_direction_n}, 5'b00001);
      for (int r = 0; r < 3; r++) begin
         @(posedge clock);
         mode <= MODE_OUTPUT; timing <= 3'b001; display_divide <= rows[r].div; out_pixel <= 32'hA5A5_0010 + r;
         wait_display_clock(1'b0); wait_display_clock(1'b1); wait_display_clock(1'b0); wait_display_clock(1'b1);
         check("taken pulse", out_pixel_taken, 1'b1);
         check("pixel out", pixel_out, out_pixel);
         for (n = 0; n < 300 && display_clock === 1'b1; n++) tick();
         check("display half period", n, rows[r].half);
      end
      @(posedge clock);
      timing <= 3'b000; // Outside the visible area nothing is taken
      wait_display_clock(1'b0); wait_display_clock(1'b1);
      check("blank taken", {out_pixel_taken, blank_n}, 2'b00);
      @(posedge clock);
      genlock_enable <= 1'b1;
      for (int l = 0; l < 3; l++) begin
         @(posedge clock);
         genlock_delay <= (l == 2) ? 8'h06 : 8'h03;
         timing <= 3'b101;
         // Display rises every 10 cycles here, so the syncs have been copied out by now
         repeat (19) @(posedge clock);
         #1;
         check("syncs out", {hsync_out, vsync_out}, 2'b10);
         @(posedge clock);
         timing <= 3'b001;
         repeat (2) tick();
         for (n = 2; n < 300 && genlock_clock !== 1'b1; n++) tick();
         meas[l] = n;
      end
      check("genlock line repeat", meas[1], meas[0]);
      check("genlock delay step", meas[2] - meas[0], 3);
      @(posedge clock);
      mode <= MODE_INPUT; in_accept <= 1'b1; vid_en <= 1'b1;
      for (int i = 0; i < 1500; i++) begin
         @(posedge clock);
         in_accept <= (i % 200) < 150;
         #1;
         if (in_word.valid === 1'b1) begin
            check("input word", in_word.data, expect_word);
            expect_word++;
         end
      end
      check("word count", 32'(expect_word > 32'h0000_0020), 32'h0000_0001);
      @(posedge clock);
      reset_n <= 1'b0; vid_en <= 1'b0; mode <= MODE_IDLE;
      @(posedge clock);
      reset_n <= 1'b1;
      tick();
      check("mid reset outputs", {pixel_oe, graphics_ready, in_word.valid, video_direction_n}, 4'b0001);
      wrap_up();
   end
endmodule // feature_connector_pixel_transfer_bench
